// [fel_defs.vh]
`ifndef FEL_DEFS_VH
`define FEL_DEFS_VH
// Depths of the two lists
`define FEL_FLT_DEPTH     16
`define FEL_ERR_DEPTH     16
// Error code width
`define FEL_CODE_W        8
// Operator function numbers
`define FEL_FN_FAULTS     10'h000
`define FEL_FN_ERRORS     10'h320
`define FEL_FN_DISP       10'h321
`define FEL_FN_XFER       10'h3e2
// Code shown on first disposition edit
`define FEL_DISP_FIRST    8'h0d
// Code whose default keeps error flag only
`define FEL_DISP_DEF_CODE 8'h66
// Disposition entry bits
`define FEL_DISP_ERR_BIT  1
`define FEL_DISP_FLT_BIT  0
`define FEL_DISP_DEF      2'h0
`define FEL_DISP_DEF_102  2'h2
// Display selector codes
`define FEL_SHOW_IDLE     3'h0
`define FEL_SHOW_CODE     3'h1
`define FEL_SHOW_ALL      3'h2
`define FEL_SHOW_END      3'h3
`define FEL_SHOW_FLAGS    3'h4
`define FEL_SHOW_RESTORE  3'h5
`define FEL_SHOW_SAVE     3'h6
`define FEL_SHOW_PROT     3'h7
// Register offsets
`define FEL_REG_FN        4'h0
`define FEL_REG_KEYS      4'h1
`define FEL_REG_ERR       4'h2
`define FEL_REG_STATUS    4'h3
`define FEL_REG_DISPLAY   4'h4
`define FEL_REG_FLTCNT    4'h5
`define FEL_REG_ERRPTR    4'h6
// Key bits in the key register
`define FEL_KEY_UP        0
`define FEL_KEY_DOWN      1
`define FEL_KEY_ENTER     2
`define FEL_KEY_LEVEL     3
`endif

// [fel_err_ring.v]
`timescale 1ns/100ps
`include "fel_defs.vh"
// Battery-backed circular error list; no reset on the storage
module fel_err_ring #(
    parameter DEPTH = `FEL_ERR_DEPTH,
    parameter CW    = `FEL_CODE_W
) (
    // Clock
    input  wire          sys_clk_i,
    // Write side
    input  wire          wr_i,
    input  wire [CW-1:0] code_i,
    // Read side
    input  wire [3:0]    rd_idx_i,
    output wire [CW-1:0] rd_code_o,
    output wire [3:0]    head_o
);
    reg [CW-1:0] mem_q [0:DEPTH-1]; // Slots, kept across reset
    reg [3:0]    head_q;            // Next slot to overwrite

    // Head survives reset too, since the store is battery backed
    initial head_q = 4'h0;

    // Newest always replaces oldest
    always @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem_q[head_q] <= code_i;
            head_q        <= head_q + 4'h1;
        end
    end

    assign rd_code_o = mem_q[rd_idx_i];
    assign head_o    = head_q;
endmodule

// [fel_logger.v]
`timescale 1ns/100ps
`include "fel_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Each code routes to fault, error, both, neither
// - Fault-enabled error lights red, shows code in function mode
// - Fault list keeps first sixteen only
// - Fault list empties on reset
// - Error-only logging stays off display
// - Error list circular, newest replaces oldest
// - Error list survives reset
// - Disposition table consulted on every error
// - Entry has error flag and fault flag
// - Up/down step flags through four combinations
// - Default entry for code 102 error only
// - Edit opens at last modified code, else 13
// - Fault view opens on clear-all item
// - Enter removes the shown fault entry
// - Removing entry leaves cause untouched
// - Faults oldest first, end marker after
// - Append fault only if flagged, not full
// - Enter then up/down moves error slot
// - Reset reloads active parameters from store
// - Transfer starts restore, keys toggle, red
// - Protected save refused, protection shown
// - Finished transfer lights green
module fel_logger #(
    parameter CW = `FEL_CODE_W,
    parameter FD = `FEL_FLT_DEPTH
) (
    // Clock and reset
    input  wire          sys_clk_i,
    input  wire          reset_i,
    // Register port
    input  wire [3:0]    addr_i,
    input  wire [15:0]   wdata_i,
    input  wire          wr_i,
    input  wire          rd_i,
    output reg  [15:0]   rdata_o,
    // Error event from the drive
    input  wire          err_valid_i,
    input  wire [CW-1:0] err_code_i,
    // Write-protect switch
    input  wire          nv_write_protect_switch_i,
    // Parameter store controls
    output reg           param_restore_o,
    output reg           param_save_o,
    // Operator indicators
    output reg           led_red_o,
    output reg           led_green_o,
    output reg  [2:0]    show_sel_o,
    output reg  [CW-1:0] show_code_o,
    output reg  [1:0]    show_flags_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Mode states, one-hot
    localparam [4:0] S_FUNC  = 5'h01;
    localparam [4:0] S_FLTV  = 5'h02;
    localparam [4:0] S_ERRV  = 5'h04;
    localparam [4:0] S_DISP  = 5'h08;
    localparam [4:0] S_XFER  = 5'h10;
    localparam       NCODE   = 1 << CW;

    // Decoded key presses from the key register
    wire       key_wr  = wr_i && (addr_i == `FEL_REG_KEYS);
    wire       k_up    = key_wr && wdata_i[`FEL_KEY_UP];
    wire       k_dn    = key_wr && wdata_i[`FEL_KEY_DOWN];
    wire       k_ent   = key_wr && wdata_i[`FEL_KEY_ENTER];
    wire       k_lvl   = key_wr && wdata_i[`FEL_KEY_LEVEL];
    wire       err_inj = wr_i && (addr_i == `FEL_REG_ERR);

    reg  [4:0]    st_q;              // Operator mode
    reg  [9:0]    fn_q;              // Selected function number
    reg  [CW-1:0] flt_q [0:FD-1];    // Fault list, oldest at 0
    reg  [4:0]    fcnt_q;            // Faults stored
    reg  [4:0]    fsel_q;            // 0 = ALL, 1..cnt entry, cnt+1 End
    reg  [3:0]    eidx_q;            // Error view slot
    reg           estep_q;           // Enter pressed, step armed
    reg  [CW-1:0] dcode_q;           // Code being edited
    reg  [CW-1:0] dlast_q;           // Last modified code
    reg           dedit_q;           // Flag editing in progress
    reg  [1:0]    dval_q;            // Flags under edit
    reg  [1:0]    disp_q [0:NCODE-1];// Disposition table
    reg           xsave_q;           // Pending save when set
    reg           prot_q;            // Protection message showing
    reg           flt_red_q;         // Live fault indicator
    reg  [CW-1:0] flt_code_q;        // Live fault code

    // Event source: drive input or software injection
    wire          ev    = err_valid_i | err_inj;
    wire [CW-1:0] ecode = err_valid_i ? err_code_i : wdata_i[CW-1:0];
    wire [1:0]    edsp  = disp_q[ecode];
    wire          ev_e  = ev && edsp[`FEL_DISP_ERR_BIT];
    wire          ev_f  = ev && edsp[`FEL_DISP_FLT_BIT];

    wire [3:0]    head;
    wire [CW-1:0] ecode_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Error list kept outside the reset domain
    fel_err_ring #(
        .DEPTH (`FEL_ERR_DEPTH),
        .CW    (CW)
    ) u_ring (
        .sys_clk_i (sys_clk_i),
        .wr_i      (ev_e),
        .code_i    (ecode),
        .rd_idx_i  (eidx_q),
        .rd_code_o (ecode_rd),
        .head_o    (head)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Disposition table: defaults loaded at reset, edited by operator
    genvar g;
    generate
        for (g = 0; g < NCODE; g = g + 1) begin : g_disp
            always @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    if (g == `FEL_DISP_DEF_CODE)
                        disp_q[g] <= `FEL_DISP_DEF_102;
                    else
                        disp_q[g] <= `FEL_DISP_DEF;
                end else if (st_q == S_DISP && dedit_q && k_ent && dcode_q == g) begin
                    disp_q[g] <= dval_q;
                end
            end
        end
    endgenerate

    // Removal requests from the fault view
    wire       in_fltv = (st_q == S_FLTV) && k_ent;
    wire       rm_all  = in_fltv && (fsel_q == 5'h00);
    wire       rm_one  = in_fltv && (fsel_q != 5'h00) && (fsel_q <= fcnt_q);
    wire       rm_any  = rm_all | rm_one;
    wire [4:0] rm_idx  = fsel_q - 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Fault list storage; removal shifts younger entries down
    generate
        for (g = 0; g < FD; g = g + 1) begin : g_flt
            always @(posedge sys_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    flt_q[g] <= {CW{1'b0}};
                end else if (rm_one && g >= rm_idx && g < FD - 1) begin
                    flt_q[g] <= flt_q[(g+1) % FD];
                end else if (ev_f && !rm_any && fcnt_q == g) begin
                    flt_q[g] <= ecode;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Fault count; append blocked once full, removal wins the cycle
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fcnt_q <= 5'h00;
        end else if (rm_all) begin
            fcnt_q <= 5'h00;
        end else if (rm_one) begin
            fcnt_q <= fcnt_q - 5'h01;
        end else if (ev_f && fcnt_q < FD) begin
            fcnt_q <= fcnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Live fault indicator; error-only events never reach it
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flt_red_q  <= 1'b0;
            flt_code_q <= {CW{1'b0}};
        end else if (ev_f) begin
            flt_red_q  <= 1'b1;
            flt_code_q <= ecode;
        end else if (k_lvl || k_ent) begin
            flt_red_q  <= 1'b0;                        // Acknowledged by operator
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operator state machine
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q    <= S_FUNC;
            fn_q    <= 10'h000;
            fsel_q  <= 5'h00;
            eidx_q  <= 4'h0;
            estep_q <= 1'b0;
            dcode_q <= `FEL_DISP_FIRST;
            dlast_q <= `FEL_DISP_FIRST;
            dedit_q <= 1'b0;
            dval_q  <= 2'h0;
            xsave_q <= 1'b0;
            prot_q  <= 1'b0;
        end else begin
            if (wr_i && addr_i == `FEL_REG_FN && st_q == S_FUNC)
                fn_q <= wdata_i[9:0];
            case (st_q)
                S_FUNC: begin
                    if (k_lvl) begin
                        case (fn_q)
                            `FEL_FN_FAULTS: begin
                                st_q   <= S_FLTV;
                                fsel_q <= 5'h00;
                            end
                            `FEL_FN_ERRORS: begin
                                st_q    <= S_ERRV;
                                eidx_q  <= head - 4'h1; // Newest slot first
                                estep_q <= 1'b0;
                            end
                            `FEL_FN_DISP: begin
                                st_q    <= S_DISP;
                                dcode_q <= dlast_q;
                                dedit_q <= 1'b0;
                            end
                            `FEL_FN_XFER: begin
                                st_q    <= S_XFER;
                                xsave_q <= 1'b0;
                                prot_q  <= 1'b0;
                            end
                            default: st_q <= S_FUNC;
                        endcase
                    end
                end
                S_FLTV: begin
                    if (k_lvl)
                        st_q <= S_FUNC;
                    else if (rm_all)
                        fsel_q <= 5'h01;               // Lands on End of empty list
                    else if (k_dn && fsel_q <= fcnt_q)
                        fsel_q <= fsel_q + 5'h01;
                    else if (k_up && fsel_q != 5'h00)
                        fsel_q <= fsel_q - 5'h01;
                end
                S_ERRV: begin
                    if (k_lvl)
                        st_q <= S_FUNC;
                    else if (k_ent)
                        estep_q <= 1'b1;
                    else if (estep_q && k_dn) begin
                        eidx_q  <= eidx_q - 4'h1;
                        estep_q <= 1'b0;
                    end else if (estep_q && k_up) begin
                        eidx_q  <= eidx_q + 4'h1;
                        estep_q <= 1'b0;
                    end
                end
                S_DISP: begin
                    if (!dedit_q) begin
                        if (k_lvl || (k_ent && k_up))
                            st_q <= S_FUNC;
                        else if (k_ent) begin
                            dedit_q <= 1'b1;
                            dval_q  <= disp_q[dcode_q];
                        end else if (k_up)
                            dcode_q <= dcode_q + 1'b1;
                        else if (k_dn)
                            dcode_q <= dcode_q - 1'b1;
                    end else begin
                        if (k_ent) begin
                            dedit_q <= 1'b0;
                            dlast_q <= dcode_q;
                        end else if (k_up)
                            dval_q <= dval_q + 2'h1;
                        else if (k_dn)
                            dval_q <= dval_q - 2'h1;
                        else if (k_lvl)
                            dedit_q <= 1'b0;           // Abandon edit
                    end
                end
                S_XFER: begin
                    if (k_lvl)
                        st_q <= S_FUNC;
                    else if (k_up || k_dn) begin
                        xsave_q <= ~xsave_q;
                        prot_q  <= 1'b0;
                    end else if (k_ent && xsave_q && nv_write_protect_switch_i)
                        prot_q <= 1'b1;
                end
                default: st_q <= S_FUNC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter transfer strobes; restore fires once after reset
    reg boot_q; // Restore still owed after reset
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            boot_q          <= 1'b1;
            param_restore_o <= 1'b0;
            param_save_o    <= 1'b0;
        end else begin
            boot_q          <= 1'b0;
            param_restore_o <= boot_q ||
                               (st_q == S_XFER && k_ent && !xsave_q);
            param_save_o    <= st_q == S_XFER && k_ent && xsave_q &&
                               !nv_write_protect_switch_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indicators and display selection
    reg xred_q; // Red after a toggle in transfer
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            xred_q       <= 1'b0;
            led_red_o    <= 1'b0;
            led_green_o  <= 1'b0;
            show_sel_o   <= `FEL_SHOW_IDLE;
            show_code_o  <= {CW{1'b0}};
            show_flags_o <= 2'h0;
        end else begin
            if (st_q != S_XFER || k_ent)
                xred_q <= 1'b0;
            else if (k_up || k_dn)
                xred_q <= 1'b1;
            show_flags_o <= dval_q;
            case (st_q)
                S_FUNC: begin
                    led_red_o   <= flt_red_q;
                    led_green_o <= 1'b0;
                    show_sel_o  <= flt_red_q ? `FEL_SHOW_CODE : `FEL_SHOW_IDLE;
                    show_code_o <= flt_code_q;
                end
                S_FLTV: begin
                    led_red_o   <= 1'b0;
                    led_green_o <= 1'b1;
                    show_sel_o  <= (fsel_q == 5'h00) ? `FEL_SHOW_ALL :
                                   (fsel_q > fcnt_q) ? `FEL_SHOW_END : `FEL_SHOW_CODE;
                    show_code_o <= flt_q[rm_idx[3:0]];
                end
                S_ERRV: begin
                    led_red_o   <= 1'b0;
                    led_green_o <= 1'b1;
                    show_sel_o  <= `FEL_SHOW_CODE;
                    show_code_o <= ecode_rd;
                end
                S_DISP: begin
                    led_red_o   <= dedit_q;
                    led_green_o <= !dedit_q;
                    show_sel_o  <= dedit_q ? `FEL_SHOW_FLAGS : `FEL_SHOW_CODE;
                    show_code_o <= dcode_q;
                end
                S_XFER: begin
                    led_red_o   <= xred_q && !k_ent;
                    led_green_o <= !xred_q || k_ent;
                    show_sel_o  <= prot_q ? `FEL_SHOW_PROT :
                                   xsave_q ? `FEL_SHOW_SAVE : `FEL_SHOW_RESTORE;
                    show_code_o <= {CW{1'b0}};
                end
                default: begin
                    led_red_o   <= 1'b0;
                    led_green_o <= 1'b0;
                    show_sel_o  <= `FEL_SHOW_IDLE;
                    show_code_o <= {CW{1'b0}};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data in the cycle after the strobe
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `FEL_REG_FN:      rdata_o <= {6'h00, fn_q};
                `FEL_REG_STATUS:  rdata_o <= {6'h00, prot_q, xsave_q, dedit_q, st_q, flt_red_q, nv_write_protect_switch_i};
                `FEL_REG_DISPLAY: rdata_o <= {8'h00, show_code_o};
                `FEL_REG_FLTCNT:  rdata_o <= {11'h000, fcnt_q};
                `FEL_REG_ERRPTR:  rdata_o <= {8'h00, eidx_q, head};
                default:          rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule

// [fel_logger_monitor.sv]
`timescale 1ns/100ps
`include "fel_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Port-level checker for the logger
module fel_logger_monitor #(
    parameter CW = 8
) (
    // Clock and reset
    input wire          sys_clk_i,
    input wire          reset_i,
    // Register port
    input wire [3:0]    addr_i,
    input wire [15:0]   wdata_i,
    input wire          wr_i,
    input wire          rd_i,
    input wire [15:0]   rdata_o,
    // Events and switch
    input wire          err_valid_i,
    input wire [CW-1:0] err_code_i,
    input wire          nv_write_protect_switch_i,
    // Outputs under watch
    input wire          param_restore_o,
    input wire          param_save_o,
    input wire          led_red_o,
    input wire          led_green_o,
    input wire [2:0]    show_sel_o,
    input wire [CW-1:0] show_code_o,
    input wire [1:0]    show_flags_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_RST_RELOAD: assert property ($past(reset_i) |=> param_restore_o)
        else $error("no reload after reset");
    AST_RESTORE_PULSE: assert property (param_restore_o |=> !param_restore_o)
        else $error("restore pulse too long");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
        else $error("read data outside read slot");
    AST_SAVE_PROT: assert property (param_save_o |-> !$past(nv_write_protect_switch_i))
        else $error("save while protected");
    AST_SAVE_GREEN: assert property (param_save_o |-> ##[0:2] led_green_o)
        else $error("no green after save");
    AST_TOGGLE_RED: assert property ($rose(show_sel_o == `FEL_SHOW_SAVE) |-> ##[0:1] led_red_o)
        else $error("no red on transfer toggle");
    AST_FLAG_STEP: assert property (show_sel_o == `FEL_SHOW_FLAGS && $past(show_sel_o) == `FEL_SHOW_FLAGS
        && $changed(show_flags_o) |-> (show_flags_o - $past(show_flags_o)) inside {2'h1, 2'h3})
        else $error("flags stepped out of sequence");
    AST_RED_CAUSE: assert property ($rose(led_red_o) |-> $past(wr_i) || $past(wr_i, 2)
        || $past(err_valid_i) || $past(err_valid_i, 2))
        else $error("red lit without cause");
    AST_END_AFTER: assert property ($rose(show_sel_o == `FEL_SHOW_END)
        |-> $past(show_sel_o) inside {`FEL_SHOW_CODE, `FEL_SHOW_ALL})
        else $error("end marker out of place");
    AST_EDIT_FROM_CODE: assert property ($rose(show_sel_o == `FEL_SHOW_FLAGS)
        |-> $past(show_sel_o) == `FEL_SHOW_CODE)
        else $error("edit not entered from a code");
    // Main scenarios reached
    COV_SAVE: cover property (param_save_o);
    COV_PROT: cover property (show_sel_o == `FEL_SHOW_PROT);
    COV_END: cover property (show_sel_o == `FEL_SHOW_END);
endmodule
bind fel_logger fel_logger_monitor #(.CW(CW)) u_mon (.*);

// [fel_op_panel.sv]
`timescale 1ns/100ps
`include "fel_defs.vh"
////////////////////////////////////////////////////////////////////////////////
// Keypad model: presses keys and picks functions over the register port
module fel_op_panel (
    // Clock
    input  wire         sys_clk_i,
    // Register port towards the logger
    output logic [3:0]  addr_o,
    output logic [15:0] wdata_o,
    output logic        wr_o,
    output logic        rd_o,
    input  wire  [15:0] rdata_i
);
    // Idle bus at time zero
    initial begin
        addr_o = 4'h0;
        wdata_o = 16'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines are scrambled so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        repeat (3) @(posedge sys_clk_i);
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge sys_clk_i);
        d = rdata_i;
    endtask
    // Single key, one per write
    task automatic key(input int k);
        wr(`FEL_REG_KEYS, 16'h1 << k);
    endtask
    // Select a function and enter its data level
    task automatic fn(input logic [9:0] n);
        wr(`FEL_REG_FN, {6'h0, n});
        key(`FEL_KEY_LEVEL);
    endtask
endmodule

// [tb_fel_logger.sv]
`timescale 1ns/100ps
`include "fel_defs.vh"
module tb_fel_logger;
    logic        sys_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic        wr, rd, red, green, rst_o, sav_o;
    logic        err_valid_i = 1'b0;
    logic [7:0]  err_code_i = 8'h0;
    logic        prot = 1'b0;
    logic [2:0]  sel;
    logic [7:0]  code;
    logic [1:0]  flags;
    int          fail_count = 0, check_count = 0, saves = 0, restores = 0, r0;
    always #20 sys_clk_i = ~sys_clk_i;
    // Count transfer pulses
    always @(posedge sys_clk_i) begin
        saves <= saves + int'(sav_o);
        restores <= restores + int'(rst_o);
    end
    fel_logger u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
        .nv_write_protect_switch_i(prot), .param_restore_o(rst_o), .param_save_o(sav_o),
        .led_red_o(red), .led_green_o(green), .show_sel_o(sel), .show_code_o(code), .show_flags_o(flags));
    fel_op_panel u_pan (.sys_clk_i(sys_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Fault count read back
    task automatic cnt(input logic [15:0] exp);
        u_pan.rd(`FEL_REG_FLTCNT, d);
        chk(d, exp, "fault count");
    endtask
    // One error occurrence from the drive
    task automatic ev(input logic [7:0] c);
        err_valid_i <= 1'b1;
        err_code_i <= c;
        @(posedge sys_clk_i);
        err_valid_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask
    task automatic t_reset;
        r0 = restores;
        reset_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk(16'(restores - r0), 16'h1, "reload");
        cnt(16'h0);
        $display("reset test done");
    endtask
    task automatic t_err_only;
        ev(`FEL_DISP_DEF_CODE);
        chk({red, sel}, {1'b0, `FEL_SHOW_IDLE}, "error only shown");
        cnt(16'h0);
        $display("error only test done");
    endtask
    // Step table for the flag editor: key then expected flags
    int          ks[7] = '{0, 0, 0, 0, 1, 1, 1};
    logic [1:0]  fs[7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h1};
    task automatic t_disp;
        u_pan.fn(`FEL_FN_DISP);
        chk({sel, code}, {`FEL_SHOW_CODE, `FEL_DISP_FIRST}, "edit opens");
        u_pan.key(`FEL_KEY_ENTER);
        chk({red, sel, flags}, {1'b1, `FEL_SHOW_FLAGS, 2'h0}, "edit flags");
        for (int i = 0; i < 7; i++) begin
            u_pan.key(ks[i]);
            chk(flags, fs[i], "flag step");
        end
        u_pan.key(`FEL_KEY_ENTER);
        chk({green, sel, code}, {1'b1, `FEL_SHOW_CODE, `FEL_DISP_FIRST}, "commit");
        u_pan.wr(`FEL_REG_KEYS, 16'h5);
        ev(`FEL_DISP_FIRST);
        chk({red, sel, code}, {1'b1, `FEL_SHOW_CODE, `FEL_DISP_FIRST}, "fault shown");
        cnt(16'h1);
        $display("disposition test done");
    endtask
    task automatic t_fill;
        repeat (16) ev(`FEL_DISP_FIRST);
        cnt(16'h10);
        $display("fill test done");
    endtask
    task automatic t_view;
        u_pan.fn(`FEL_FN_FAULTS);
        chk(sel, `FEL_SHOW_ALL, "view opens");
        u_pan.key(`FEL_KEY_DOWN);
        chk({sel, code}, {`FEL_SHOW_CODE, `FEL_DISP_FIRST}, "first entry");
        repeat (16) u_pan.key(`FEL_KEY_DOWN);
        chk(sel, `FEL_SHOW_END, "end marker");
        u_pan.key(`FEL_KEY_LEVEL);
        u_pan.fn(`FEL_FN_FAULTS);
        u_pan.key(`FEL_KEY_DOWN);
        u_pan.key(`FEL_KEY_ENTER);
        cnt(16'hf);
        u_pan.key(`FEL_KEY_LEVEL);
        u_pan.fn(`FEL_FN_FAULTS);
        u_pan.key(`FEL_KEY_ENTER);
        cnt(16'h0);
        u_pan.key(`FEL_KEY_LEVEL);
        $display("fault view test done");
    endtask
    task automatic t_xfer;
        r0 = restores;
        u_pan.fn(`FEL_FN_XFER);
        chk(sel, `FEL_SHOW_RESTORE, "starts restore");
        u_pan.key(`FEL_KEY_UP);
        chk({red, sel}, {1'b1, `FEL_SHOW_SAVE}, "toggle save");
        u_pan.key(`FEL_KEY_DOWN);
        u_pan.key(`FEL_KEY_ENTER);
        chk({green, 8'(restores - r0)}, {1'b1, 8'h1}, "restore done");
        u_pan.key(`FEL_KEY_UP);
        prot <= 1'b1;
        u_pan.key(`FEL_KEY_ENTER);
        chk({sel, 8'(saves)}, {`FEL_SHOW_PROT, 8'h0}, "save refused");
        prot <= 1'b0;
        u_pan.key(`FEL_KEY_LEVEL);
        u_pan.fn(`FEL_FN_XFER);
        u_pan.key(`FEL_KEY_DOWN);
        u_pan.key(`FEL_KEY_ENTER);
        chk({green, 8'(saves)}, {1'b1, 8'h1}, "save done");
        u_pan.key(`FEL_KEY_LEVEL);
        $display("transfer test done");
    endtask
    // Error list outlives reset; one error-only code recorded earlier
    task automatic t_errv;
        u_pan.fn(`FEL_FN_ERRORS);
        chk({green, sel, code}, {1'b1, `FEL_SHOW_CODE, `FEL_DISP_DEF_CODE}, "error kept");
        u_pan.key(`FEL_KEY_ENTER);
        u_pan.key(`FEL_KEY_UP);
        u_pan.rd(`FEL_REG_ERRPTR, d);
        chk(d, 16'h11, "error slot step");
        repeat (15) u_pan.wr(`FEL_REG_ERR, 16'h66);
        u_pan.rd(`FEL_REG_ERRPTR, d);
        chk(d, 16'h10, "ring wraps");
        $display("errors done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence; last reset must empty the list
    initial begin
        t_reset();
        t_err_only();
        t_disp();
        t_fill();
        t_view();
        t_xfer();
        ev(`FEL_DISP_FIRST);
        t_reset();
        t_errv();
        end_sim();
    end
    // Watchdog far beyond the test length
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        end_sim();
    end
endmodule
